// *** dv/fsp_cpu_model.sv ***
// CPU core stand-in: register port cycles and store/load pulses.
// Assumes the testbench calls its tasks and owns the clock.
`timescale 1ns/10ps
module fsp_cpu_model
  import fsp_pkg::*;
(
  input wire logic clock_i,
  input wire logic ee_busy_i,
  input wire logic [15:0] rdata_i,
  input wire logic [7:0] ldata_i,
  output logic [3:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  output logic store_o,
  output logic load_o
);
  initial begin
    {addr_o, wdata_o, wr_o, rd_o, store_o, load_o} = '0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask
  task automatic lpm(output logic [7:0] b);
    @(posedge clock_i);
    load_o <= 1'b1;
    @(posedge clock_i);
    load_o <= 1'b0;
    #1 b = ldata_i;
  endtask
  // No other work runs between control write and store, so nothing can break the pair.
  task automatic spm(input logic [15:0] cmd, input logic fire, output logic ok);
    logic [15:0] c;
    ok = 1'b0;
    for (int i = 0; i < 64 && !ok; i++) begin
      rd(FSP_REG_CTRL, c);
      ok = !c[FSP_BIT_ENABLE] && !ee_busy_i;
    end
    if (ok) begin
      wr(FSP_REG_CTRL, cmd);
      store_o <= fire;
      @(posedge clock_i);
      store_o <= 1'b0;
    end
  endtask
  // Control write, then n idle edges, then the store pulse; probes the arming window.
  task automatic spm_at(input logic [15:0] cmd, input int n);
    wr(FSP_REG_CTRL, cmd);
    repeat (n) @(posedge clock_i);
    store_o <= 1'b1;
    @(posedge clock_i);
    store_o <= 1'b0;
  endtask
endmodule

// *** dv/fsp_top_assertions.sv ***
// Checker for the flash self-programming block, bound to fsp_top.
// Assumes it sees only the top module's ports on the single core clock.
`timescale 1ns/10ps
module fsp_checker
  import fsp_pkg::*;
#(
  parameter int unsigned OP_CYCLES = FSP_OP_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic boot_size_sel_hi_i,
  input wire logic boot_size_sel_lo_i,
  input wire logic store_i,
  input wire logic [12:0] fetch_addr_i,
  input wire logic fetch_ok_o,
  input wire logic [12:0] boot_reset_addr_o,
  input wire logic [12:0] flash_addr_o,
  input wire logic erase_o,
  input wire logic program_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire logic [1:0] fuse_w = {boot_size_sel_hi_i, boot_size_sel_lo_i};
  // The boot section always ends at the top word, so its start is the top minus its size.
  wire logic [13:0] boot_w = 14'h2000 - (14'h0400 >> fuse_w);
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside a read answer");
  unmapped_zero_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) > 4'h6
    |-> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
  op_excl_a: assert property (!(erase_o && program_o))
    else $error("erase and write at once");
  page_aligned_a: assert property ((erase_o || program_o) |-> flash_addr_o[5:0] == 6'h00)
    else $error("operation address not page aligned");
  blocking_read_region_fetch_a: assert property ($past(fetch_addr_i) >= 13'h1c00 |-> fetch_ok_o)
    else $error("fetch from upper region refused");
  rww_block_a: assert property ($past(erase_o) && $past(fetch_addr_i) < 13'h1c00
    |-> !fetch_ok_o) else $error("lower region readable during erase");
  boot_map_a: assert property ($stable(fuse_w) [*5] |-> boot_reset_addr_o == boot_w[12:0])
    else $error("boot address does not follow fuses");
  op_cause_a: assert property ($rose(erase_o || program_o) |-> $past(store_i))
    else $error("operation started without store");
endmodule
bind fsp_top fsp_checker #(.OP_CYCLES(OP_CYCLES)) u_chk (.clock_i, .rst_b_i, .reg_addr_i,
  .reg_rd_i, .reg_rdata_o, .boot_size_sel_hi_i, .boot_size_sel_lo_i, .store_i, .fetch_addr_i,
  .fetch_ok_o, .boot_reset_addr_o, .flash_addr_o, .erase_o, .program_o);

// *** dv/fsp_top_tb_top.sv ***
// Testbench for fsp_top: boot map, buffer load, erase and write, refusals.
// Assumes fsp_cpu_model issues every bus cycle and store/load pulse.
`timescale 1ns/10ps
module fsp_top_tb_top;
  import fsp_pkg::*;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic boot_size_sel_hi_i = 1'b0;
  logic boot_size_sel_lo_i = 1'b0;
  logic eeprom_write_strobe_i = 1'b0;
  logic [12:0] fetch_addr_i = 13'h0000;
  wire logic [3:0] reg_addr_i;
  wire logic [15:0] reg_wdata_i, reg_rdata_o;
  wire logic reg_wr_i, reg_rd_i, store_i, load_i, fetch_ok_o, erase_o, program_o, irq_o;
  wire logic [7:0] load_data_o;
  wire logic [12:0] boot_reset_addr_o, flash_addr_o;
  int miscompares = 0;
  int num_checks = 0;
  logic [15:0] v;
  logic ok;
  always #12.5 clock_i = ~clock_i;
  fsp_top #(.OP_CYCLES(20)) dut (.clock_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .boot_size_sel_hi_i, .boot_size_sel_lo_i, .eeprom_write_strobe_i,
    .store_i, .load_i, .fetch_addr_i, .load_data_o, .fetch_ok_o, .boot_reset_addr_o,
    .flash_addr_o, .erase_o, .program_o, .irq_o);
  fsp_cpu_model cpu (.clock_i, .ee_busy_i(eeprom_write_strobe_i), .rdata_i(reg_rdata_o),
    .ldata_i(load_data_o), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .wr_o(reg_wr_i),
    .rd_o(reg_rd_i), .store_o(store_i), .load_o(load_i));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic fetch_at(input logic [12:0] a, input logic exp);
    @(posedge clock_i);
    fetch_addr_i <= a;
    tick(2);
    chk({15'h0, fetch_ok_o}, {15'h0, exp});
  endtask
  task automatic test_boot;
    logic [12:0] start [4] = '{13'h1c00, 13'h1e00, 13'h1f00, 13'h1f80};
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      {boot_size_sel_hi_i, boot_size_sel_lo_i} <= i[1:0];
      tick(5);
      chk({3'h0, boot_reset_addr_o}, {3'h0, start[i]});
      cpu.rd(FSP_REG_INFO, v);
      chk(v, 16'h0400 >> i);
    end
    $display("boot size test done");
  endtask
  task automatic load_word(input logic [15:0] ptr, input logic [15:0] d);
    cpu.wr(FSP_REG_PTR, ptr);
    cpu.wr(FSP_REG_DATA, d);
    cpu.spm(16'h0001, 1'b1, ok);
    chk({15'h0, ok}, 16'h0001);
  endtask
  task automatic test_load;
    logic [7:0] b;
    cpu.wr(FSP_REG_IRQ_MASK, 16'h0000);
    load_word(16'hc00a, 16'hbeef);
    load_word(16'h000c, 16'h1234);
    cpu.rd(FSP_REG_CTRL, v);
    chk(v, 16'h0000);
    cpu.rd(FSP_REG_IRQ_STAT, v);
    chk(v, 16'h0001);
    chk({15'h0, irq_o}, 16'h0000);
    cpu.wr(FSP_REG_IRQ_MASK, 16'h0001);
    tick(2);
    chk({15'h0, irq_o}, 16'h0001);
    cpu.wr(FSP_REG_IRQ_STAT, 16'h0007);
    tick(2);
    chk({15'h0, irq_o}, 16'h0000);
    cpu.wr(FSP_REG_PTR, 16'h000a);
    cpu.lpm(b);
    chk({8'h0, b}, 16'h00ef);
    cpu.wr(FSP_REG_PTR, 16'h000b);
    cpu.lpm(b);
    chk({8'h0, b}, 16'h00be);
    cpu.rd(FSP_REG_BUF_RD, v);
    chk(v, 16'hbeef);
    $display("buffer load test done");
  endtask
  task automatic test_op(input logic [15:0] cmd, input logic [6:0] page);
    int n;
    logic [7:0] b;
    cpu.wr(FSP_REG_PTR, {2'b10, page, 7'h00});
    cpu.spm(cmd, 1'b1, ok);
    chk({15'h0, ok}, 16'h0001);
    #1;
    chk({14'h0, erase_o, program_o}, {14'h0, cmd[1], cmd[2]});
    chk({3'h0, flash_addr_o}, {3'h0, page, 6'h00});
    fetch_at(13'h1bff, 1'b0);
    fetch_at(13'h1c00, 1'b1);
    cpu.lpm(b);
    chk({8'h0, b}, 16'h0000);
    cpu.rd(FSP_REG_IRQ_STAT, v);
    chk(v & 16'h0004, 16'h0004);
    for (n = 0; n < 60 && (erase_o || program_o); n++) tick(1);
    chk({14'h0, erase_o, program_o}, 16'h0000);
    cpu.rd(FSP_REG_CTRL, v);
    chk(v & 16'h0041, 16'h0040);
    fetch_at(13'h0000, 1'b0);
    cpu.spm(16'h0011, 1'b1, ok);
    cpu.rd(FSP_REG_CTRL, v);
    chk(v, 16'h0000);
    fetch_at(13'h1bff, 1'b1);
    $display("page operation test done");
  endtask
  task automatic test_refuse;
    cpu.wr(FSP_REG_IRQ_STAT, 16'h0007);
    cpu.spm(16'h0003, 1'b0, ok);
    tick(6);
    cpu.rd(FSP_REG_CTRL, v);
    chk(v, 16'h0000);
    cpu.rd(FSP_REG_IRQ_STAT, v);
    chk(v, 16'h0002);
    cpu.wr(FSP_REG_IRQ_STAT, 16'h0007);
    cpu.spm_at(16'h0001, 3);
    tick(2);
    cpu.rd(FSP_REG_IRQ_STAT, v);
    chk(v, 16'h0001);
    cpu.wr(FSP_REG_IRQ_STAT, 16'h0007);
    cpu.spm_at(16'h0001, 4);
    tick(2);
    cpu.rd(FSP_REG_IRQ_STAT, v);
    chk(v, 16'h0002);
    @(posedge clock_i);
    eeprom_write_strobe_i <= 1'b1;
    tick(3);
    cpu.wr(FSP_REG_CTRL, 16'h0001);
    cpu.rd(FSP_REG_CTRL, v);
    chk(v, 16'h0000);
    @(posedge clock_i);
    eeprom_write_strobe_i <= 1'b0;
    cpu.rd(4'hf, v);
    chk(v, 16'h0000);
    $display("refusal test done");
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    tick(4);
    chk({3'h0, boot_reset_addr_o}, 16'h1c00);
    test_boot();
    test_load();
    test_op(16'h0003, 7'h05);
    test_op(16'h0005, 7'h6f);
    test_refuse();
    tally_and_finish();
  end
  // A hang anywhere above is cut short here and counted as a mismatch.
  initial begin
    repeat (20000) @(posedge clock_i);
    miscompares++;
    tally_and_finish();
  end
endmodule

// *** hw/fsp_busy_timer.sv ***
// Down-counter that times one flash erase or write operation.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/10ps
module fsp_busy_timer
  import fsp_pkg::*;
#(
  parameter int unsigned CYCLES = FSP_OP_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic done_q;
  wire logic running = (cnt_q != 32'h0);
  wire logic last = (cnt_q == 32'h1);

  assign cnt_d = start_i ? 32'(CYCLES) : (running ? cnt_q - 32'h1 : cnt_q);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 32'h0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= last && !start_i;
    end
  end

  assign busy_o = running;
  assign done_o = done_q;
endmodule

// *** hw/fsp_pkg.sv ***
// Package for the flash self-programming address and partition block.
// Assumes a single core clock; shared by the top module and the timer leaf.
package fsp_pkg;
  localparam int unsigned FSP_PC_W = 13;
  localparam int unsigned FSP_WORD_W = 6;
  localparam int unsigned FSP_PAGE_W = FSP_PC_W - FSP_WORD_W;
  localparam int unsigned FSP_PTR_W = 16;
  localparam int unsigned FSP_COUNTER_TOP_BIT = 12;
  localparam int unsigned FSP_PAGE_OFFSET_TOP_BIT = 5;
  localparam int unsigned FSP_POINTER_COUNTER_TOP_BIT = 13;
  localparam int unsigned FSP_POINTER_PAGE_OFFSET_TOP_BIT = 6;
  localparam logic [6:0] FSP_BLOCKING_READ_REGION_FIRST_PAGE = 7'h70;
  localparam logic [12:0] FSP_BOOT_START_128 = 13'h1f80;
  localparam logic [12:0] FSP_BOOT_START_256 = 13'h1f00;
  localparam logic [12:0] FSP_BOOT_START_512 = 13'h1e00;
  localparam logic [12:0] FSP_BOOT_START_1024 = 13'h1c00;
  localparam logic [10:0] FSP_BOOT_WORDS_128 = 11'h080;
  localparam logic [10:0] FSP_BOOT_WORDS_256 = 11'h100;
  localparam logic [10:0] FSP_BOOT_WORDS_512 = 11'h200;
  localparam logic [10:0] FSP_BOOT_WORDS_1024 = 11'h400;
  // Register offsets on the plain register port.
  localparam logic [3:0] FSP_REG_CTRL = 4'h0;
  localparam logic [3:0] FSP_REG_PTR = 4'h1;
  localparam logic [3:0] FSP_REG_DATA = 4'h2;
  localparam logic [3:0] FSP_REG_INFO = 4'h3;
  localparam logic [3:0] FSP_REG_IRQ_STAT = 4'h4;
  localparam logic [3:0] FSP_REG_IRQ_MASK = 4'h5;
  localparam logic [3:0] FSP_REG_BUF_RD = 4'h6;
  // Control register bit positions.
  localparam int unsigned FSP_BIT_ENABLE = 0;
  localparam int unsigned FSP_BIT_ERASE = 1;
  localparam int unsigned FSP_BIT_WRITE = 2;
  localparam int unsigned FSP_BIT_REENABLE = 4;
  localparam int unsigned FSP_BIT_BUSY = 6;
  // Interrupt status bit positions.
  localparam int unsigned FSP_IRQ_DONE = 0;
  localparam int unsigned FSP_IRQ_TIMEOUT = 1;
  localparam int unsigned FSP_IRQ_BLOCKED = 2;
  localparam logic [15:0] FSP_RST_WORD = 16'h0000;
  localparam logic [2:0] FSP_RST_IRQ = 3'h0;
  // Cycles after a control write during which the store command is accepted.
  localparam logic [2:0] FSP_ARM_CYCLES = 3'h4;
  localparam int unsigned FSP_OP_TIME_US = 4000;
  localparam int unsigned FSP_CLK_MHZ = 40;
  localparam int unsigned FSP_OP_CYCLES = FSP_OP_TIME_US * FSP_CLK_MHZ;
  typedef enum logic [1:0] {
    FSP_IDLE,
    FSP_ARMED,
    FSP_BUSY
  } fsp_state_t;
endpackage

// *** hw/fsp_top.sv ***
// Flash self-programming address map, command sequencer and page buffer.
// Assumes the CPU core drives the plain register port and the store/load strobes.
`timescale 1ns/10ps
module fsp_top
  import fsp_pkg::*;
#(
  parameter int unsigned OP_CYCLES = FSP_OP_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic boot_size_sel_hi_i,
  input wire logic boot_size_sel_lo_i,
  input wire logic eeprom_write_strobe_i,
  input wire logic store_i,
  input wire logic load_i,
  input wire logic [12:0] fetch_addr_i,
  output logic [7:0] load_data_o,
  output logic fetch_ok_o,
  output logic [12:0] boot_reset_addr_o,
  output logic [12:0] flash_addr_o,
  output logic erase_o,
  output logic program_o,
  output logic irq_o
);
  fsp_state_t state_q, state_d;
  logic [15:0] ptr_q;
  logic [15:0] data_q;
  logic [7:0] ctrl_q, ctrl_d;
  logic busy_region_q;
  logic [2:0] arm_q;
  logic [2:0] stat_q, mask_q;
  logic [15:0] rdata_q;
  logic [7:0] load_q;
  logic fetch_q;
  logic [12:0] boot_q, addr_q;
  logic erase_q, program_q, irq_q;
  logic [15:0] page_buf_q [64];
  logic [1:0] sel_hi_s, sel_lo_s, ee_s;
  logic op_busy, op_done;

  // Fuse pins and the EEPROM write strobe pass two flops before use; store and load strobes are used directly.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_hi_s <= 2'h0;
      sel_lo_s <= 2'h0;
      ee_s <= 2'h0;
    end else begin
      sel_hi_s <= {sel_hi_s[0], boot_size_sel_hi_i};
      sel_lo_s <= {sel_lo_s[0], boot_size_sel_lo_i};
      ee_s <= {ee_s[0], eeprom_write_strobe_i};
    end
  end

  wire logic [1:0] boot_sel = {sel_hi_s[1], sel_lo_s[1]};
  wire logic [12:0] boot_start = (boot_sel == 2'h3) ? FSP_BOOT_START_128 :
                                 (boot_sel == 2'h2) ? FSP_BOOT_START_256 :
                                 (boot_sel == 2'h1) ? FSP_BOOT_START_512 :
                                 FSP_BOOT_START_1024;
  wire logic [10:0] boot_words = (boot_sel == 2'h3) ? FSP_BOOT_WORDS_128 :
                                 (boot_sel == 2'h2) ? FSP_BOOT_WORDS_256 :
                                 (boot_sel == 2'h1) ? FSP_BOOT_WORDS_512 :
                                 FSP_BOOT_WORDS_1024;

  // Pointer bits 15:14 are dropped and bit 0 plays no part in word addressing.
  wire logic [12:0] ptr_pc = ptr_q[FSP_POINTER_COUNTER_TOP_BIT:1];
  wire logic [6:0] page_number_field = ptr_q[FSP_POINTER_COUNTER_TOP_BIT:7];
  wire logic [5:0] word_in_page_field = ptr_q[FSP_POINTER_PAGE_OFFSET_TOP_BIT:1];
  wire logic byte_sel = ptr_q[0];
  wire logic [6:0] fetch_page = fetch_addr_i[FSP_COUNTER_TOP_BIT:FSP_WORD_W];
  wire logic fetch_in_blocking = (fetch_page >= FSP_BLOCKING_READ_REGION_FIRST_PAGE);
  wire logic ptr_in_blocking = (ptr_pc[12:6] >= FSP_BLOCKING_READ_REGION_FIRST_PAGE);

  wire logic wr_ctrl = reg_wr_i && (reg_addr_i == FSP_REG_CTRL);
  wire logic wr_ptr = reg_wr_i && (reg_addr_i == FSP_REG_PTR);
  wire logic wr_data = reg_wr_i && (reg_addr_i == FSP_REG_DATA);
  wire logic wr_stat = reg_wr_i && (reg_addr_i == FSP_REG_IRQ_STAT);
  wire logic wr_mask = reg_wr_i && (reg_addr_i == FSP_REG_IRQ_MASK);
  // A control write while the EEPROM is writing is dropped.
  wire logic ctrl_take = wr_ctrl && !ee_s[1] && (state_q == FSP_IDLE);
  wire logic [7:0] cmd = ctrl_q;
  wire logic cmd_erase = cmd[FSP_BIT_ERASE];
  wire logic cmd_write = cmd[FSP_BIT_WRITE];
  wire logic cmd_reen = cmd[FSP_BIT_REENABLE];
  wire logic cmd_load = !cmd_erase && !cmd_write && !cmd_reen;
  wire logic fire = (state_q == FSP_ARMED) && store_i;
  wire logic timed_out = (state_q == FSP_ARMED) && !store_i && (arm_q == 3'h1);
  wire logic start_op = fire && (cmd_erase || cmd_write);
  wire logic do_load = fire && cmd_load;
  wire logic do_reen = fire && cmd_reen && !op_busy;
  // A load into the concurrent region while blocked is a software fault.
  wire logic lpm_blocked = load_i && busy_region_q && !ptr_in_blocking;

  fsp_busy_timer #(
    .CYCLES(OP_CYCLES)
  ) u_timer (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .start_i(start_op),
    .busy_o(op_busy),
    .done_o(op_done)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      FSP_IDLE: begin
        if (ctrl_take && reg_wdata_i[FSP_BIT_ENABLE]) begin
          state_d = FSP_ARMED;
        end
      end
      FSP_ARMED: begin
        if (start_op) begin
          state_d = FSP_BUSY;
        end else if (fire || timed_out) begin
          state_d = FSP_IDLE;
        end
      end
      FSP_BUSY: begin
        if (op_done) begin
          state_d = FSP_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_take) begin
      ctrl_d = reg_wdata_i[7:0];
    end else if (timed_out || (fire && !start_op) || op_done) begin
      ctrl_d = 8'h00;
    end
  end

  wire logic [2:0] irq_set = {lpm_blocked, timed_out, op_done || do_load || do_reen};
  wire logic [2:0] irq_clr = wr_stat ? reg_wdata_i[2:0] : 3'h0;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= FSP_IDLE;
      ctrl_q <= 8'h00;
      arm_q <= 3'h0;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      arm_q <= ctrl_take ? FSP_ARM_CYCLES : (arm_q != 3'h0 ? arm_q - 3'h1 : 3'h0);
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ptr_q <= FSP_RST_WORD;
      data_q <= FSP_RST_WORD;
      stat_q <= FSP_RST_IRQ;
      mask_q <= FSP_RST_IRQ;
    end else begin
      if (wr_ptr) begin
        ptr_q <= reg_wdata_i;
      end
      if (wr_data) begin
        data_q <= reg_wdata_i;
      end
      if (wr_mask) begin
        mask_q <= reg_wdata_i[2:0];
      end
      stat_q <= (stat_q & ~irq_clr) | irq_set;
    end
  end

  // Busy stays set from the start of an erase or write until re-enable.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_region_q <= 1'b0;
    end else if (start_op) begin
      busy_region_q <= 1'b1;
    end else if (do_reen) begin
      busy_region_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (do_load) begin
      page_buf_q[word_in_page_field] <= data_q;
    end
  end

  wire logic [15:0] ctrl_view = {8'h00, 1'b0, busy_region_q, 2'h0, ctrl_q[3:0]};
  wire logic [15:0] info_view = {3'h0, boot_start} ^ 16'h0000;
  wire logic [15:0] rdata_d =
    (reg_addr_i == FSP_REG_CTRL) ? ctrl_view :
    (reg_addr_i == FSP_REG_PTR) ? ptr_q :
    (reg_addr_i == FSP_REG_DATA) ? data_q :
    (reg_addr_i == FSP_REG_INFO) ? {5'h00, boot_words} :
    (reg_addr_i == FSP_REG_IRQ_STAT) ? {13'h0000, stat_q} :
    (reg_addr_i == FSP_REG_IRQ_MASK) ? {13'h0000, mask_q} :
    (reg_addr_i == FSP_REG_BUF_RD) ? page_buf_q[word_in_page_field] :
    16'h0000;
  wire logic [15:0] flash_word = page_buf_q[word_in_page_field];
  // Flash array is outside; byte lane from the buffer copy of the addressed word.
  wire logic [7:0] load_byte = byte_sel ? flash_word[15:8] : flash_word[7:0];
  // The page-write address keeps only the page; word bits are forced to zero.
  wire logic [12:0] op_addr = {page_number_field, 6'h00};
  wire logic fetch_ok_d = !(op_busy || busy_region_q) || fetch_in_blocking;

  // Read data are zero outside the answer cycle, so the core may OR several slaves together.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= reg_rd_i ? rdata_d : 16'h0000;
    end
  end

  // A refused program-memory read returns zero rather than stale buffer data.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      load_q <= 8'h00;
    end else begin
      load_q <= (load_i && !lpm_blocked) ? load_byte : 8'h00;
    end
  end

  // Permission lags the fetch address by one cycle; the core must allow for that.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fetch_q <= 1'b1;
    end else begin
      fetch_q <= fetch_ok_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_q <= FSP_BOOT_START_1024;
    end else begin
      boot_q <= info_view[12:0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_q <= 13'h0000;
    end else begin
      addr_q <= start_op ? op_addr : addr_q;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      erase_q <= 1'b0;
    end else begin
      erase_q <= start_op ? cmd_erase : (op_done ? 1'b0 : erase_q);
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      program_q <= 1'b0;
    end else begin
      program_q <= start_op ? cmd_write : (op_done ? 1'b0 : program_q);
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign reg_rdata_o = rdata_q;
  assign load_data_o = load_q;
  assign fetch_ok_o = fetch_q;
  assign boot_reset_addr_o = boot_q;
  assign flash_addr_o = addr_q;
  assign erase_o = erase_q;
  assign program_o = program_q;
  assign irq_o = irq_q;
endmodule
